// ==== rtl/ddc_pkg.sv ====
/*
 Constants for the two-channel downconversion control block:
 register offsets, field positions, masks, reset values and codes.
 Assumes an 8-bit register port with byte-wide registers.
*/
package ddc_pkg;
	localparam int REG_W = 8;
	localparam int NCO_W = 32;
	localparam int NCO_BYTES = 4;
	localparam int CHANS = 2;

	localparam logic [7:0] OFS_ROUTE = 8'h24;
	localparam logic [7:0] OFS_DECIM = 8'h25;
	localparam logic [7:0] OFS_MIXER = 8'h26;
	localparam logic [7:0] OFS_NCO_A = 8'h2A;
	localparam logic [7:0] OFS_NCO_B = 8'h31;

	localparam logic [7:0] RST_ROUTE = 8'h00;
	localparam logic [7:0] RST_DECIM = 8'h00;
	localparam logic [7:0] RST_MIXER = 8'h00;
	localparam logic [7:0] RST_NCO = 8'h00;

	// Writable bits; the rest read back as zero
	localparam logic [7:0] MASK_ROUTE = 8'h3E;
	localparam logic [7:0] MASK_DECIM = 8'hF9;
	localparam logic [7:0] MASK_MIXER = 8'hFF;

	localparam int ROUTE_AVG_BIT = 5;
	localparam int ROUTE_SEL_LO = 3;
	localparam int ROUTE_FEAT_BIT = 2;
	localparam int ROUTE_EN_BIT = 1;
	localparam int DECIM_SWEN_BIT = 7;
	localparam int DECIM_RATIO_LO = 4;
	localparam int DECIM_REAL_BIT = 3;
	localparam int DECIM_INV_BIT = 0;
	localparam int MIX_GAIN_A_LO = 6;
	localparam int PHASE_RESET_CHAN_A_BIT = 5;
	localparam int MIX_FS4_A_BIT = 4;
	localparam int MIX_GAIN_B_LO = 2;
	localparam int PHASE_RESET_CHAN_B_BIT = 1;
	localparam int MIX_FS4_B_BIT = 0;

	localparam logic [1:0] SRC_STRAIGHT = 2'h0;
	localparam logic [1:0] SRC_ALL_A = 2'h1;
	localparam logic [1:0] SRC_ALL_B = 2'h2;
	localparam logic [1:0] SRC_AVERAGE = 2'h3;

	localparam logic [1:0] GAIN_NONE = 2'h0;
	localparam logic [1:0] GAIN_3DB = 2'h1;
	localparam logic [1:0] GAIN_6DB = 2'h2;

	localparam logic [2:0] RATIO_MAX = 3'h5;

	// Mixer coefficients in units of 1/256; 3 dB gain is x*181/128
	localparam logic signed [9:0] COEF_ONE = 10'sh100;
	localparam logic signed [9:0] COEF_ROOT = 10'sh0B5;
	localparam int COEF_SHIFT = 8;
	localparam int GAIN_SHIFT = 7;
endpackage

// ==== rtl/ddc_channel_path.sv ====
/*
 One filter path: oscillator, mixer, quarter-rate rotation, gain,
 block-average decimator and the feature-path bypass.
 Assumes samples and controls arrive on sys_clk from registered logic.
*/
`timescale 1ns/10ps
`default_nettype none
module ddc_channel_path #(
	parameter int IN_W = 14
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Sample in
	input wire logic signed [IN_W-1:0] sample_in,
	input wire logic sample_valid,
	// Controls
	input wire logic feature_en,
	input wire logic downconverter_enable,
	input wire logic real_mode,
	input wire logic phase_invert,
	input wire logic quarter_mix,
	input wire logic [1:0] gain_code,
	input wire logic [2:0] ratio_code,
	input wire logic phase_reset_pulse,
	input wire logic [ddc_pkg::NCO_W-1:0] freq_word,
	// Result
	output logic signed [IN_W+2:0] out_i,
	output logic signed [IN_W+2:0] out_q,
	output logic out_valid
);
	localparam int MIX_W = IN_W + 2;
	localparam int GAIN_W = IN_W + 3;
	localparam int ACC_W = GAIN_W + 5;
	localparam int PROD_W = IN_W + 10;
	localparam int GP_W = MIX_W + 10;

	function automatic logic signed [9:0] cos_coef(input logic [2:0] k);
		case (k)
			3'h0: cos_coef = ddc_pkg::COEF_ONE;
			3'h1, 3'h7: cos_coef = ddc_pkg::COEF_ROOT;
			3'h2, 3'h6: cos_coef = 10'sh000;
			3'h3, 3'h5: cos_coef = -ddc_pkg::COEF_ROOT;
			default: cos_coef = -ddc_pkg::COEF_ONE;
		endcase
	endfunction

	function automatic logic signed [GAIN_W-1:0] apply_gain(input logic signed [MIX_W-1:0] v,
			input logic [1:0] code);
		logic signed [GP_W-1:0] p;
		p = GP_W'(v) * GP_W'(ddc_pkg::COEF_ROOT);
		case (code)
			ddc_pkg::GAIN_3DB: apply_gain = GAIN_W'(p >>> ddc_pkg::GAIN_SHIFT);
			ddc_pkg::GAIN_6DB: apply_gain = GAIN_W'(v) <<< 1;
			default: apply_gain = GAIN_W'(v);
		endcase
	endfunction

	logic [ddc_pkg::NCO_W-1:0] phase_r, nco_word_r;
	logic [1:0] quarter_r;
	logic signed [ACC_W-1:0] acc_i_r, acc_q_r;
	logic [5:0] count_r;
	logic [4:0] cfg_prev_r;
	logic signed [GAIN_W-1:0] out_i_r, out_q_r;
	logic out_valid_r;

	// Phase is coarse, eight steps per turn: exact at quarter rate
	wire [2:0] raw_idx = phase_r[ddc_pkg::NCO_W-1 -: 3];
	wire [2:0] cos_idx = phase_invert ? 3'(3'h0 - raw_idx) : raw_idx; // [R13]
	wire [2:0] sin_idx = 3'(cos_idx - 3'h2);
	wire signed [PROD_W-1:0] prod_i = PROD_W'(sample_in) * PROD_W'(cos_coef(cos_idx));
	wire signed [PROD_W-1:0] prod_q = PROD_W'(sample_in) * PROD_W'(cos_coef(sin_idx));
	wire signed [MIX_W-1:0] mix_i = MIX_W'(prod_i >>> ddc_pkg::COEF_SHIFT);
	wire signed [MIX_W-1:0] mix_q = MIX_W'(-(prod_q >>> ddc_pkg::COEF_SHIFT));
	logic signed [MIX_W-1:0] rot_i, rot_q;
	always_comb begin
		rot_i = mix_i;
		rot_q = mix_q;
		if (quarter_mix) begin // [R18] [R19]
			case (quarter_r)
				2'h1: begin rot_i = mix_q; rot_q = -mix_i; end
				2'h2: begin rot_i = -mix_i; rot_q = -mix_q; end
				2'h3: begin rot_i = -mix_q; rot_q = mix_i; end
				default: begin rot_i = mix_i; rot_q = mix_q; end
			endcase
		end
	end
	// Real mode: low-pass only, no mixer and so no mixer gain
	wire signed [GAIN_W-1:0] feed_i = real_mode ? GAIN_W'(sample_in) : apply_gain(rot_i, gain_code); // [R11] [R14] [R15]
	wire signed [GAIN_W-1:0] feed_q = real_mode ? '0 : apply_gain(rot_q, gain_code); // [R11]
	wire filter_on = feature_en && downconverter_enable; // [R8] [R9]
	wire [4:0] cfg_now = {filter_on, real_mode, ratio_code};
	wire cfg_change = cfg_now != cfg_prev_r;
	wire [2:0] ratio_eff = (ratio_code > ddc_pkg::RATIO_MAX) ? 3'h0 : ratio_code; // [R10]
	wire [5:0] block_len = 6'(6'h01 << ratio_eff);
	wire signed [ACC_W-1:0] sum_i = acc_i_r + ACC_W'(feed_i);
	wire signed [ACC_W-1:0] sum_q = acc_q_r + ACC_W'(feed_q);

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_r <= '0;
			nco_word_r <= '0;
			quarter_r <= 2'h0;
		end else if (phase_reset_pulse) begin // [R16] [R17] [R20]
			phase_r <= '0;
			nco_word_r <= freq_word;
			quarter_r <= 2'h0;
		end else if (sample_valid) begin
			phase_r <= phase_r + nco_word_r; // [R20]
			quarter_r <= quarter_r + 2'h1;
		end
	end

	// A change of filter enable, real mode or ratio restarts the block so no stale partial sum leaks out
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_i_r <= '0;
			acc_q_r <= '0;
			count_r <= 6'h00;
			cfg_prev_r <= 5'h00;
			out_i_r <= '0;
			out_q_r <= '0;
			out_valid_r <= 1'b0;
		end else begin
			out_valid_r <= 1'b0;
			cfg_prev_r <= cfg_now;
			if (cfg_change) begin
				acc_i_r <= '0;
				acc_q_r <= '0;
				count_r <= 6'h00;
			end else if (sample_valid && !filter_on) begin // [R8]
				out_i_r <= GAIN_W'(sample_in);
				out_q_r <= '0;
				out_valid_r <= 1'b1;
			end else if (sample_valid && count_r >= block_len - 6'h01) begin // [R22]
				out_i_r <= GAIN_W'(sum_i >>> ratio_eff);
				out_q_r <= GAIN_W'(sum_q >>> ratio_eff);
				out_valid_r <= 1'b1;
				acc_i_r <= '0;
				acc_q_r <= '0;
				count_r <= 6'h00;
			end else if (sample_valid) begin
				acc_i_r <= sum_i;
				acc_q_r <= sum_q;
				count_r <= count_r + 6'h01;
			end
		end
	end
	assign out_i = out_i_r;
	assign out_q = out_q_r;
	assign out_valid = out_valid_r;

	logic [6:0] hc_cnt_r;
	logic hc_ok_r;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			hc_cnt_r <= 7'h00;
			hc_ok_r <= 1'b0;
		end else begin
			if (out_valid_r)
				hc_cnt_r <= sample_valid ? 7'h01 : 7'h00;
			else if (sample_valid)
				hc_cnt_r <= hc_cnt_r + 7'h01;
			hc_ok_r <= cfg_change ? 1'b0 : (out_valid_r | hc_ok_r);
		end
	end

	chk_decim_rate: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R22] [R10]
		out_valid_r && hc_ok_r && filter_on |-> hc_cnt_r == 7'(block_len))
		else $error("decimated output spacing wrong");
	chk_bypass_path: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R8]
		sample_valid && !feature_en && !cfg_change
		|=> out_valid_r && out_i_r == GAIN_W'($past(sample_in)) && out_q_r == '0)
		else $error("feature bypass not direct");
	chk_phase_reload: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R16] [R17]
		phase_reset_pulse |=> phase_r == '0 && nco_word_r == $past(freq_word))
		else $error("phase reset did not reload");
	chk_gain_double: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R14] [R15]
		sample_valid && filter_on && !real_mode && !quarter_mix && !cfg_change
		&& ratio_code == 3'h0 && gain_code == ddc_pkg::GAIN_6DB && phase_r == '0
		&& nco_word_r == '0 && !phase_reset_pulse
		|=> out_valid_r && out_i_r == (GAIN_W'($past(sample_in)) <<< 1))
		else $error("6 dB gain wrong");
endmodule
`default_nettype wire

// ==== rtl/dual_channel_downconverter_config.sv ====
/*
 Register file and routing for the two-channel downconversion stage,
 with two filter path instances behind a source switch.
 Assumes samples on sys_clk from the converter cores and a register
 master that keeps strobes one cycle long and never both at once.
*/
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// R1 - Average enable forms (A+B)/2; clear means no averaging.
// R2 - Software enables the source switch and selects code 11 for averaging.
// R3 - Averaging also needs the decimation filter on and feature path set; the code gates it only on average enable, switch enable and code 11.
// R4 - Source code 00 routes A to path A and B to path B.
// R5 - Code 01 feeds A to both paths; code 10 feeds B to both.
// R6 - Code 11 feeds the averaged samples to both paths.
// R7 - Source code acts only while switch enable is set; else straight.
// R8 - Feature path select clear bypasses feature block; set passes through it.
// R9 - Downconverter enable turns the decimation filter on for both channels.
// R10 - Ratio field: bypass, 2, 4, 8, 16, 32; other codes unused.
// R11 - Real output bit selects real low-pass decimation without mixing.
// R12 - In real mode software should set oscillator frequency to zero.
// R13 - Phase invert bit negates oscillator phase in the mixer.
// R14 - Channel A gain field adds none, 3 dB or 6 dB.
// R15 - Channel B gain field uses the same gain encoding.
// R16 - Toggling channel A phase reset resets phase, loads new word.
// R17 - Toggling channel B phase reset resets phase, loads new word.
// R18 - Channel A quarter-rate mixing bit enables fs/4 mixing in path A.
// R19 - Channel B quarter-rate mixing bit enables fs/4 mixing in path B.
// R20 - Each oscillator is tuned by a 32-bit frequency word.
// R21 - Unused bits are written zero and read back as zero.
// R22 - Decimating by N gives one output per N inputs, with valid.
module dual_channel_downconverter_config #(
	parameter int IN_W = 14
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Converter samples
	input wire logic signed [IN_W-1:0] sample_a,
	input wire logic signed [IN_W-1:0] sample_b,
	input wire logic sample_valid,
	// Path A result
	output logic signed [IN_W+2:0] out_i_a,
	output logic signed [IN_W+2:0] out_q_a,
	output logic out_valid_a,
	// Path B result
	output logic signed [IN_W+2:0] out_i_b,
	output logic signed [IN_W+2:0] out_q_b,
	output logic out_valid_b
);
	localparam int OUT_W = IN_W + 3;
	localparam int NB = ddc_pkg::CHANS * ddc_pkg::NCO_BYTES;

	initial begin
		if (IN_W < 8 || IN_W > 24)
			$error("IN_W must lie between 8 and 24");
	end

	// Control registers
	logic [7:0] path_routing_control_r;
	logic [7:0] decimation_control_r;
	logic [7:0] mixer_control_r;
	logic [7:0] nco_byte_r [0:NB-1];
	logic [7:0] reg_rdata_r;
	logic [1:0] res_prev_r;
	logic [1:0] res_pulse_r;

	// Address decode
	wire hit_route = reg_addr == ddc_pkg::OFS_ROUTE;
	wire hit_decim = reg_addr == ddc_pkg::OFS_DECIM;
	wire hit_mixer = reg_addr == ddc_pkg::OFS_MIXER;
	wire hit_nco_a = reg_addr >= ddc_pkg::OFS_NCO_A
		&& reg_addr < ddc_pkg::OFS_NCO_A + 8'h04;
	wire hit_nco_b = reg_addr >= ddc_pkg::OFS_NCO_B
		&& reg_addr < ddc_pkg::OFS_NCO_B + 8'h04;
	wire [7:0] ofs_in_a = reg_addr - ddc_pkg::OFS_NCO_A;
	wire [7:0] ofs_in_b = reg_addr - ddc_pkg::OFS_NCO_B;
	logic [2:0] nco_idx;
	logic nco_hit;
	always_comb begin
		nco_idx = 3'h0;
		nco_hit = 1'b0;
		if (hit_nco_a) begin
			nco_idx = {1'b0, ofs_in_a[1:0]};
			nco_hit = 1'b1;
		end else if (hit_nco_b) begin
			nco_idx = {1'b1, ofs_in_b[1:0]};
			nco_hit = 1'b1;
		end
	end

	// Masked writes keep the unused positions at zero
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			path_routing_control_r <= ddc_pkg::RST_ROUTE;
			decimation_control_r <= ddc_pkg::RST_DECIM;
			mixer_control_r <= ddc_pkg::RST_MIXER;
		end else if (reg_wr) begin
			if (hit_route)
				path_routing_control_r <= reg_wdata & ddc_pkg::MASK_ROUTE; // [R21]
			else if (hit_decim)
				decimation_control_r <= reg_wdata & ddc_pkg::MASK_DECIM; // [R21]
			else if (hit_mixer)
				mixer_control_r <= reg_wdata & ddc_pkg::MASK_MIXER;
		end
	end

	// Frequency words, byte 0 at the lowest address
	genvar gi;
	generate
		for (gi = 0; gi < NB; gi++) begin : g_nco
			always_ff @(posedge sys_clk or negedge arst_n) begin
				if (!arst_n)
					nco_byte_r[gi] <= ddc_pkg::RST_NCO;
				else if (reg_wr && nco_hit && nco_idx == 3'(gi))
					nco_byte_r[gi] <= reg_wdata; // [R20]
			end
		end
	endgenerate

	// Read mux; data stand only in the cycle after the strobe
	logic [7:0] rd_mux;
	always_comb begin
		if (hit_route)
			rd_mux = path_routing_control_r;
		else if (hit_decim)
			rd_mux = decimation_control_r;
		else if (hit_mixer)
			rd_mux = mixer_control_r;
		else if (nco_hit)
			rd_mux = nco_byte_r[nco_idx];
		else
			rd_mux = 8'h00;
	end
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			reg_rdata_r <= 8'h00;
		else
			reg_rdata_r <= reg_rd ? rd_mux : 8'h00;
	end
	assign reg_rdata = reg_rdata_r;

	// Phase reset bits act on any change, in either direction
	wire [1:0] res_now = {mixer_control_r[ddc_pkg::PHASE_RESET_CHAN_B_BIT],
		mixer_control_r[ddc_pkg::PHASE_RESET_CHAN_A_BIT]};
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			res_prev_r <= 2'h0;
			res_pulse_r <= 2'h0;
		end else begin
			res_prev_r <= res_now;
			res_pulse_r <= res_now ^ res_prev_r; // [R16] [R17]
		end
	end

	// Field extraction
	wire avg_en = path_routing_control_r[ddc_pkg::ROUTE_AVG_BIT];
	wire [1:0] src_sel = path_routing_control_r[ddc_pkg::ROUTE_SEL_LO +: 2];
	wire feature_en = path_routing_control_r[ddc_pkg::ROUTE_FEAT_BIT];
	wire downconverter_enable = path_routing_control_r[ddc_pkg::ROUTE_EN_BIT];
	wire switch_en = decimation_control_r[ddc_pkg::DECIM_SWEN_BIT];
	wire [2:0] ratio_code = decimation_control_r[ddc_pkg::DECIM_RATIO_LO +: 3];
	wire real_mode = decimation_control_r[ddc_pkg::DECIM_REAL_BIT];
	wire phase_invert = decimation_control_r[ddc_pkg::DECIM_INV_BIT];
	wire [1:0] gain_code [0:1];
	wire quarter_mix [0:1];
	assign gain_code[0] = mixer_control_r[ddc_pkg::MIX_GAIN_A_LO +: 2]; // [R14]
	assign gain_code[1] = mixer_control_r[ddc_pkg::MIX_GAIN_B_LO +: 2]; // [R15]
	// Quarter-rate mixing is meaningful only in complex decimation
	assign quarter_mix[0] = mixer_control_r[ddc_pkg::MIX_FS4_A_BIT] && !real_mode; // [R18]
	assign quarter_mix[1] = mixer_control_r[ddc_pkg::MIX_FS4_B_BIT] && !real_mode; // [R19]
	wire [ddc_pkg::NCO_W-1:0] freq_word [0:1];
	assign freq_word[0] = {nco_byte_r[3], nco_byte_r[2], nco_byte_r[1], nco_byte_r[0]};
	assign freq_word[1] = {nco_byte_r[7], nco_byte_r[6], nco_byte_r[5], nco_byte_r[4]};

	// Source switch; averaging needs both its enable and code 11
	wire signed [IN_W:0] pair_sum = (IN_W+1)'(sample_a) + (IN_W+1)'(sample_b);
	wire signed [IN_W-1:0] avg_sample = IN_W'(pair_sum >>> 1); // [R1]
	wire [1:0] src_eff = switch_en ? src_sel : ddc_pkg::SRC_STRAIGHT; // [R7]
	wire use_avg = src_eff == ddc_pkg::SRC_AVERAGE && avg_en; // [R1] [R6]
	logic signed [IN_W-1:0] path_in [0:1];
	always_comb begin
		path_in[0] = sample_a; // [R4]
		path_in[1] = sample_b;
		if (use_avg) begin
			path_in[0] = avg_sample; // [R6]
			path_in[1] = avg_sample;
		end else if (src_eff == ddc_pkg::SRC_ALL_A) begin
			path_in[1] = sample_a; // [R5]
		end else if (src_eff == ddc_pkg::SRC_ALL_B) begin
			path_in[0] = sample_b; // [R5]
		end
	end

	// Filter paths
	wire signed [OUT_W-1:0] res_i [0:1];
	wire signed [OUT_W-1:0] res_q [0:1];
	wire res_valid [0:1];
	generate
		for (gi = 0; gi < ddc_pkg::CHANS; gi++) begin : g_path
			ddc_channel_path #(
				.IN_W(IN_W)
			) u_path (
				.sys_clk(sys_clk),
				.arst_n(arst_n),
				.sample_in(path_in[gi]),
				.sample_valid(sample_valid),
				.feature_en(feature_en), // [R8]
				.downconverter_enable(downconverter_enable), // [R9]
				.real_mode(real_mode), // [R11]
				.phase_invert(phase_invert), // [R13]
				.quarter_mix(quarter_mix[gi]),
				.gain_code(gain_code[gi]),
				.ratio_code(ratio_code), // [R10]
				.phase_reset_pulse(res_pulse_r[gi]),
				.freq_word(freq_word[gi]),
				.out_i(res_i[gi]),
				.out_q(res_q[gi]),
				.out_valid(res_valid[gi])
			);
		end
	endgenerate
	assign out_i_a = res_i[0];
	assign out_q_a = res_q[0];
	assign out_valid_a = res_valid[0];
	assign out_i_b = res_i[1];
	assign out_q_b = res_q[1];
	assign out_valid_b = res_valid[1];

	// Checks on routing, register answers and toggle detection
	chk_route_straight: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R4] [R7]
		!switch_en || src_sel == ddc_pkg::SRC_STRAIGHT
		|-> path_in[0] == sample_a && path_in[1] == sample_b)
		else $error("straight routing broken");
	chk_route_single: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R5]
		switch_en && src_sel == ddc_pkg::SRC_ALL_A
		|-> path_in[0] == sample_a && path_in[1] == sample_a)
		else $error("converter A not on both paths");
	chk_route_avg: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R1] [R6]
		switch_en && src_sel == ddc_pkg::SRC_AVERAGE && avg_en
		|-> path_in[0] == IN_W'(pair_sum >>> 1) && path_in[1] == path_in[0])
		else $error("average routing wrong");
	chk_read_reserved: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R21]
		reg_rd && hit_route |=> reg_rdata[7:6] == 2'h0 && reg_rdata[0] == 1'b0)
		else $error("reserved bits read nonzero");
	chk_read_timing: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R21]
		reg_rd && hit_decim |=> reg_rdata == $past(decimation_control_r)
		##1 (reg_rdata == 8'h00 || $past(reg_rd)))
		else $error("read data timing wrong");
	chk_phase_toggle: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R16] [R17]
		reg_wr && hit_mixer && ((reg_wdata ^ mixer_control_r) & 8'h22) != 8'h00
		|=> ##1 res_pulse_r == $past(res_now ^ res_prev_r) && res_pulse_r != 2'h0)
		else $error("phase reset toggle missed");
endmodule
`default_nettype wire

// ==== rtl/unused_placeholder_none.sv ====
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ==== test/converter_pair_model.sv ====
/*
 Model of the two converter cores: emits bursts of ramp samples.
 Assumes go is a one-cycle request from the bench on sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module converter_pair_model #(
	parameter int IN_W = 14
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Burst request
	input wire logic go,
	input wire logic spaced,
	input wire logic [7:0] n_samp,
	input wire logic signed [IN_W-1:0] base_a,
	input wire logic signed [IN_W-1:0] base_b,
	// Sample stream
	output logic signed [IN_W-1:0] sample_a,
	output logic signed [IN_W-1:0] sample_b,
	output logic sample_valid
);
	logic [7:0] left_r;
	logic [IN_W-1:0] idx_r;
	logic gap_r;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			left_r <= 8'h00;
			idx_r <= '0;
			gap_r <= 1'b0;
			sample_valid <= 1'b0;
			sample_a <= '0;
			sample_b <= '0;
		end else if (!go && left_r != 8'h00 && !gap_r) begin
			sample_valid <= 1'b1;
			sample_a <= base_a + $signed(idx_r);
			sample_b <= base_b - $signed(idx_r);
			idx_r <= idx_r + 1'b1;
			left_r <= left_r - 8'h01;
			gap_r <= spaced;
		end else begin
			// Stale data would hide a missing qualifier check
			sample_valid <= 1'b0;
			sample_a <= ~sample_a;
			sample_b <= ~sample_b;
			gap_r <= 1'b0;
			if (go) begin
				left_r <= n_samp;
				idx_r <= '0;
			end
		end
	end
endmodule
`default_nettype wire

// ==== test/dual_channel_downconverter_config_test.sv ====
/*
 Self-checking bench: register port tasks, routing, decimation, gain.
 Assumes the converter model above drives the sample inputs.
*/
`timescale 1ns/10ps
`default_nettype none
module dual_channel_downconverter_config_test;
	localparam int IN_W = 14;
	logic sys_clk;
	logic arst_n;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic signed [IN_W-1:0] sample_a;
	logic signed [IN_W-1:0] sample_b;
	logic sample_valid;
	logic signed [IN_W+2:0] out_i_a;
	logic signed [IN_W+2:0] out_q_a;
	logic signed [IN_W+2:0] out_i_b;
	logic signed [IN_W+2:0] out_q_b;
	logic out_valid_a;
	logic out_valid_b;
	logic go;
	logic spaced;
	logic [7:0] n_samp;
	logic signed [IN_W-1:0] base_a;
	logic signed [IN_W-1:0] base_b;
	logic [7:0] route_v [6] = '{8'h26, 8'h2E, 8'h36, 8'h3E, 8'h2E, 8'h1E};
	logic [7:0] decim_v [6] = '{8'h88, 8'h88, 8'h88, 8'h88, 8'h08, 8'h88};
	int exp_a [6] = '{300, 300, 100, 200, 300, 300};
	int exp_b [6] = '{100, 300, 100, 200, 100, 100};
	int n_errors;
	int comparisons;
	int n_out;
	int n;
	int e;

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	dual_channel_downconverter_config #(.IN_W(IN_W)) dut (.sys_clk(sys_clk), .arst_n(arst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sample_a(sample_a), .sample_b(sample_b),
		.sample_valid(sample_valid), .out_i_a(out_i_a), .out_q_a(out_q_a),
		.out_valid_a(out_valid_a), .out_i_b(out_i_b), .out_q_b(out_q_b),
		.out_valid_b(out_valid_b));

	converter_pair_model #(.IN_W(IN_W)) src (.sys_clk(sys_clk), .arst_n(arst_n), .go(go),
		.spaced(spaced), .n_samp(n_samp), .base_a(base_a), .base_b(base_b),
		.sample_a(sample_a), .sample_b(sample_b), .sample_valid(sample_valid));

	always @(posedge sys_clk) begin
		if (out_valid_a === 1'b1)
			n_out <= n_out + 1;
		if (out_valid_a !== out_valid_b)
			fail("valid strobes differ");
	end

	task automatic fail(input string msg);
		n_errors++;
		$display("[ERR] %0t %s", $time, msg);
	endtask

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
			fail($sformatf("reg got %h exp %h", got, exp));
	endtask

	task automatic cmp_val(input logic signed [31:0] got, input logic signed [31:0] exp);
		comparisons++;
		if (got !== exp)
			fail($sformatf("value got %0d exp %0d", got, exp));
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		cmp8(reg_rdata, exp);
	endtask

	// Burst of cnt samples, then expect exactly outs output strobes
	task automatic run(input int cnt, input int a, input int b, input int outs, input logic sp);
		int k;
		@(posedge sys_clk);
		n_out <= 0;
		go <= 1'b1;
		spaced <= sp;
		n_samp <= 8'(cnt);
		base_a <= IN_W'(a);
		base_b <= IN_W'(b);
		@(posedge sys_clk);
		go <= 1'b0;
		for (k = 0; k < 400 && n_out < outs; k++)
			@(posedge sys_clk);
		if (n_out < outs) begin
			fail("output timeout");
			give_verdict();
		end
		repeat (4) @(posedge sys_clk);
		#1;
		cmp_val(n_out, outs);
	endtask

	function automatic int gain_of(input int v, input int g);
		return g == 1 ? (v * 181) >>> 7 : (g == 2 ? v * 2 : v);
	endfunction

	initial begin
		arst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		go = 1'b0;
		spaced = 1'b0;
		n_samp = 8'h00;
		base_a = '0;
		base_b = '0;
		n_errors = 0;
		comparisons = 0;
		n_out = 0;
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		rd_chk(8'h24, 8'h00);
		rd_chk(8'h25, 8'h00);
		rd_chk(8'h26, 8'h00);
		rd_chk(8'h2A, 8'h00);
		wr(8'h24, 8'hFF);
		rd_chk(8'h24, 8'h3E);
		wr(8'h25, 8'hFF);
		rd_chk(8'h25, 8'hF9);
		wr(8'h26, 8'hFF);
		rd_chk(8'h26, 8'hFF);
		wr(8'h40, 8'h5A);
		rd_chk(8'h40, 8'h00);
		wr(8'h34, 8'hC3);
		rd_chk(8'h34, 8'hC3);
		// Word B back to zero before the toggle loads it into the oscillator
		wr(8'h34, 8'h00);
		wr(8'h24, 8'h00);
		wr(8'h25, 8'h00);
		wr(8'h26, 8'h00);
		$display("test registers done");
		// Slow partner: one idle cycle between samples
		for (e = 0; e < 2; e++) begin
			wr(8'h24, e ? 8'h04 : 8'h00);
			run(3, 100, -50, 3, 1'b1);
			cmp_val(out_i_a, 102);
			cmp_val(out_q_a, 0);
			cmp_val(out_i_b, -52);
		end
		$display("test bypass done");
		// Real mode keeps the mixer out, NCO words stay zero
		for (e = 0; e < 6; e++) begin
			wr(8'h25, decim_v[e]);
			wr(8'h24, route_v[e]);
			run(1, 300, 100, 1, 1'b0);
			cmp_val(out_i_a, exp_a[e]);
			cmp_val(out_i_b, exp_b[e]);
			cmp_val(out_q_a, 0);
		end
		$display("test routing done");
		wr(8'h24, 8'h06);
		for (e = 1; e < 6; e++) begin
			wr(8'h25, 8'h08 | 8'(e << 4));
			n = 1 << e;
			run(n, 10, 0, 1, 1'b0);
			cmp_val(out_i_a, 10 + ((n - 1) >> 1));
			cmp_val(out_i_b, -(n >> 1));
		end
		$display("test decimation done");
		wr(8'h25, 8'h00);
		for (e = 0; e < 4; e++) begin
			wr(8'h26, 8'((e << 6) | (e << 2)));
			run(1, 200, -200, 1, 1'b0);
			cmp_val(out_i_a, gain_of(200, e));
			cmp_val(out_i_b, gain_of(-200, e));
			cmp_val(out_q_b, 0);
		end
		$display("test gain done");
		give_verdict();
	end
endmodule
`default_nettype wire
